/* File: core/tpw_pkg.sv */
/*
  package for the 16-bit pwm waveform timer: waveform mode codes, output mode codes,
  fixed tops, prescale divisors and reset values.
  assumes nothing of its surroundings.
*/
package tpw_pkg;
  localparam logic [3:0] WM_PC8 = 4'h1;
  localparam logic [3:0] WM_PC9 = 4'h2;
  localparam logic [3:0] WM_PC10 = 4'h3;
  localparam logic [3:0] WM_FP8 = 4'h5;
  localparam logic [3:0] WM_FP9 = 4'h6;
  localparam logic [3:0] WM_FP10 = 4'h7;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_A = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'hA;
  localparam logic [3:0] WM_PC_A = 4'hB;
  localparam logic [3:0] WM_FP_CAP = 4'hE;
  localparam logic [3:0] WM_FP_A = 4'hF;
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_NONINV = 2'h2;
  localparam logic [1:0] OM_INV = 2'h3;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_DIV1 = 3'h1;
  localparam logic [2:0] PS_DIV8 = 3'h2;
  localparam logic [2:0] PS_DIV64 = 3'h3;
  localparam logic [2:0] PS_DIV256 = 3'h4;
  localparam logic [2:0] PS_DIV1024 = 3'h5;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST = 10'h3FF;
endpackage : tpw_pkg

/* File: core/tpw_prescaler.sv */
/*
  prescaler: gives a one-cycle timer tick every 1, 8, 64, 256 or 1024 clocks.
  assumes a select code from the package; select stop gives no tick.
*/
`timescale 1ns/1ps
module tpw_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] prescale_select,
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
  } tpw_ps_s;
  tpw_ps_s s_q;
  tpw_ps_s s_d;
  logic [9:0] last;

  always_comb begin
    case (prescale_select)
      tpw_pkg::PS_DIV8: last = tpw_pkg::DIV8_LAST;
      tpw_pkg::PS_DIV64: last = tpw_pkg::DIV64_LAST;
      tpw_pkg::PS_DIV256: last = tpw_pkg::DIV256_LAST;
      tpw_pkg::PS_DIV1024: last = tpw_pkg::DIV1024_LAST;
      default: last = 10'h000;
    endcase
    s_d = s_q;
    if (prescale_select == tpw_pkg::PS_STOP || s_q.cnt >= last) begin
      s_d.cnt = 10'h000;
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
    tick = (prescale_select != tpw_pkg::PS_STOP) && (s_q.cnt >= last);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : tpw_prescaler

/* File: core/tpw_channel.sv */
/*
  one compare channel: double-buffered compare value and waveform output.
  assumes the core supplies the tick, the count, the direction and the turning-point strobes.
*/
`timescale 1ns/1ps
module tpw_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] res_mask,
  input wire logic buffered,
  input wire logic load_now,
  input wire logic fast_mode,
  input wire logic dual_mode,
  input wire logic counting_down,
  input wire logic at_top,
  input wire logic toggle_ok,
  input wire logic [1:0] channel_output_mode,
  input wire logic output_pin_direction_bit,
  input wire logic cmp_write,
  input wire logic [15:0] cmp_wdata,
  output logic [15:0] compare_value_register,
  output logic compare_match,
  output logic compare_output_pin
);
  typedef struct packed {
    logic [15:0] buf_v;
    logic [15:0] act;
    logic wave;
    logic pin;
  } tpw_ch_s;
  tpw_ch_s s_q;
  tpw_ch_s s_d;
  logic match;
  logic inv;

  always_comb begin
    s_d = s_q;
    inv = (channel_output_mode == tpw_pkg::OM_INV);
    match = (counter_value == s_q.act);
    if (cmp_write) begin
      s_d.buf_v = cmp_wdata & res_mask;
    end
    if (!buffered && cmp_write) begin
      s_d.act = cmp_wdata & res_mask;
    end else if (tick && load_now) begin
      s_d.act = s_q.buf_v;
    end
    if (tick) begin
      if (channel_output_mode == tpw_pkg::OM_TOGGLE) begin
        if (toggle_ok && match) begin
          s_d.wave = ~s_q.wave;
        end
      end else if (channel_output_mode != tpw_pkg::OM_OFF) begin
        if (fast_mode) begin
          if (match) begin
            s_d.wave = ~inv;
          end else if (at_top) begin
            s_d.wave = inv;
          end
        end else if (dual_mode && match) begin
          if (at_top) begin
            s_d.wave = ~inv;
          end else if (counter_value == tpw_pkg::BOTTOM) begin
            s_d.wave = inv;
          end else begin
            s_d.wave = counting_down ? ~inv : inv;
          end
        end
      end
    end
    s_d.pin = output_pin_direction_bit && (channel_output_mode != tpw_pkg::OM_OFF)
              && s_d.wave;
  end

  assign compare_value_register = s_q.act;
  assign compare_match = tick && match;
  assign compare_output_pin = s_q.pin;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : tpw_channel

/* File: core/tpw_timer.sv */
/*
  16-bit pwm waveform timer: counter, top select, overflow and top flags, three channels.
  assumes software drives the configuration ports synchronously and clears flags by pulse.
*/
// How it works
// - output mode 2 non-inverted, 3 inverted
// - fast pwm: set at match, clear at wrap
// - pin shows waveform only when direction output
// - fast period is prescale times top plus one
// - fast compare zero gives one-cycle spike
// - fast compare equal top gives constant level
// - fast mode 15 toggle on channel a
// - phase correct counts up then down, tops
// - dual slope: clear up-match, set down-match
// - counter holds top one timer cycle
// - phase correct sets overflow at zero
// - phase correct loads compares at top, flags
// - fixed top masks compare high bits
// - phase correct extremes give constant levels
// - mode 11 toggle gives square wave
// - modes 8 and 9 frequency correct
// - phase correct slopes follow old, new top
// - phase correct period twice prescale times top
// - mode 8 capture top, 9 compare a
// - frequency correct loads at zero, overflow
// - fast compare a buffered, loaded at top
`timescale 1ns/1ps
module tpw_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] waveform_mode_select,
  input wire logic [2:0] prescale_select,
  input wire logic [1:0] channel_a_output_mode,
  input wire logic [1:0] channel_b_output_mode,
  input wire logic [1:0] channel_c_output_mode,
  input wire logic [2:0] output_pin_direction_bit,
  input wire logic [2:0] cmp_write,
  input wire logic [15:0] cmp_wdata,
  input wire logic cap_write,
  input wire logic [15:0] cap_wdata,
  input wire logic overflow_clear,
  input wire logic capture_clear,
  input wire logic compare_a_clear,
  output logic [15:0] counter_value,
  output logic [15:0] compare_a_register,
  output logic [15:0] capture_top_register,
  output logic overflow_flag,
  output logic capture_flag,
  output logic compare_a_flag,
  output logic channel_a_output_pin,
  output logic channel_b_output_pin,
  output logic channel_c_output_pin
);
  typedef enum logic [1:0] {
    UP = 2'b01,
    DOWN = 2'b10
  } tpw_dir_e;
  typedef struct packed {
    logic [15:0] cnt;
    tpw_dir_e dir;
    logic [15:0] cap;
    logic ovf;
    logic capf;
    logic cmpaf;
  } tpw_core_s;
  tpw_core_s s_q;
  tpw_core_s s_d;

  logic tick;
  logic [15:0] top;
  logic [15:0] res_mask;
  logic fast_mode;
  logic pc_mode;
  logic pfc_mode;
  logic dual_mode;
  logic top_is_a;
  logic top_is_cap;
  logic at_top;
  logic at_bottom;
  logic load_now;
  logic [2:0] ch_pin;
  logic match_a;
  logic [15:0] ocr_a;
  logic buffered;
  logic counting_down;
  logic toggle_a;
  logic [1:0] om [3];

  assign om[0] = channel_a_output_mode;
  assign om[1] = channel_b_output_mode;
  assign om[2] = channel_c_output_mode;

  tpw_prescaler u_ps (
    .clk(clk),
    .rst(rst),
    .prescale_select(prescale_select),
    .tick(tick)
  );

  always_comb begin
    fast_mode = 1'b0;
    pc_mode = 1'b0;
    pfc_mode = 1'b0;
    top_is_a = 1'b0;
    top_is_cap = 1'b0;
    res_mask = 16'hFFFF;
    top = tpw_pkg::TOP_8BIT;
    // fixed tops also mask compare writes to their resolution
    case (waveform_mode_select)
      tpw_pkg::WM_PC8: begin
        pc_mode = 1'b1;
        top = tpw_pkg::TOP_8BIT;
        res_mask = tpw_pkg::TOP_8BIT;
      end
      tpw_pkg::WM_PC9: begin
        pc_mode = 1'b1;
        top = tpw_pkg::TOP_9BIT;
        res_mask = tpw_pkg::TOP_9BIT;
      end
      tpw_pkg::WM_PC10: begin
        pc_mode = 1'b1;
        top = tpw_pkg::TOP_10BIT;
        res_mask = tpw_pkg::TOP_10BIT;
      end
      tpw_pkg::WM_FP8: begin
        fast_mode = 1'b1;
        top = tpw_pkg::TOP_8BIT;
        res_mask = tpw_pkg::TOP_8BIT;
      end
      tpw_pkg::WM_FP9: begin
        fast_mode = 1'b1;
        top = tpw_pkg::TOP_9BIT;
        res_mask = tpw_pkg::TOP_9BIT;
      end
      tpw_pkg::WM_FP10: begin
        fast_mode = 1'b1;
        top = tpw_pkg::TOP_10BIT;
        res_mask = tpw_pkg::TOP_10BIT;
      end
      tpw_pkg::WM_PFC_CAP: begin
        pfc_mode = 1'b1;
        top_is_cap = 1'b1;
        top = s_q.cap;
      end
      tpw_pkg::WM_PFC_A: begin
        pfc_mode = 1'b1;
        top_is_a = 1'b1;
        top = ocr_a;
      end
      tpw_pkg::WM_PC_CAP: begin
        pc_mode = 1'b1;
        top_is_cap = 1'b1;
        top = s_q.cap;
      end
      tpw_pkg::WM_PC_A: begin
        pc_mode = 1'b1;
        top_is_a = 1'b1;
        top = ocr_a;
      end
      tpw_pkg::WM_FP_CAP: begin
        fast_mode = 1'b1;
        top_is_cap = 1'b1;
        top = s_q.cap;
      end
      tpw_pkg::WM_FP_A: begin
        fast_mode = 1'b1;
        top_is_a = 1'b1;
        top = ocr_a;
      end
      default: begin
        fast_mode = 1'b0;
      end
    endcase
    dual_mode = pc_mode | pfc_mode;
    at_top = (s_q.cnt == top);
    at_bottom = (s_q.cnt == tpw_pkg::BOTTOM);
    load_now = (fast_mode | pc_mode) ? at_top : (pfc_mode & at_bottom);
  end

  // compare registers double buffered only in pwm modes
  assign buffered = fast_mode | dual_mode;
  assign counting_down = (s_q.dir == DOWN);
  // only channel a may toggle, and only while it also sets top
  assign toggle_a = top_is_a && (fast_mode | pc_mode);

  tpw_channel u_ch_a (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .counter_value(s_q.cnt),
    .res_mask(res_mask),
    .buffered(buffered),
    .load_now(load_now),
    .fast_mode(fast_mode),
    .dual_mode(dual_mode),
    .counting_down(counting_down),
    .at_top(at_top),
    .toggle_ok(toggle_a),
    .channel_output_mode(om[0]),
    .output_pin_direction_bit(output_pin_direction_bit[0]),
    .cmp_write(cmp_write[0]),
    .cmp_wdata(cmp_wdata),
    .compare_value_register(ocr_a),
    .compare_match(match_a),
    .compare_output_pin(ch_pin[0])
  );

  tpw_channel u_ch_b (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .counter_value(s_q.cnt),
    .res_mask(res_mask),
    .buffered(buffered),
    .load_now(load_now),
    .fast_mode(fast_mode),
    .dual_mode(dual_mode),
    .counting_down(counting_down),
    .at_top(at_top),
    .toggle_ok(1'b0),
    .channel_output_mode(om[1]),
    .output_pin_direction_bit(output_pin_direction_bit[1]),
    .cmp_write(cmp_write[1]),
    .cmp_wdata(cmp_wdata),
    .compare_value_register(),
    .compare_match(),
    .compare_output_pin(ch_pin[1])
  );

  tpw_channel u_ch_c (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .counter_value(s_q.cnt),
    .res_mask(res_mask),
    .buffered(buffered),
    .load_now(load_now),
    .fast_mode(fast_mode),
    .dual_mode(dual_mode),
    .counting_down(counting_down),
    .at_top(at_top),
    .toggle_ok(1'b0),
    .channel_output_mode(om[2]),
    .output_pin_direction_bit(output_pin_direction_bit[2]),
    .cmp_write(cmp_write[2]),
    .cmp_wdata(cmp_wdata),
    .compare_value_register(),
    .compare_match(),
    .compare_output_pin(ch_pin[2])
  );

  always_comb begin
    s_d = s_q;
    if (cap_write) begin
      s_d.cap = cap_wdata;
    end
    if (overflow_clear) begin
      s_d.ovf = 1'b0;
    end
    if (capture_clear) begin
      s_d.capf = 1'b0;
    end
    if (compare_a_clear) begin
      s_d.cmpaf = 1'b0;
    end
    // set wins: the set terms follow the clears
    if (match_a && !(dual_mode && top_is_a)) begin
      s_d.cmpaf = 1'b1;
    end
    if (tick) begin
      // single slope: wrap to bottom after top
      if (fast_mode) begin
        if (at_top) begin
          s_d.cnt = tpw_pkg::BOTTOM;
          s_d.ovf = 1'b1;
          if (top_is_a) begin
            s_d.cmpaf = 1'b1;
          end
          if (top_is_cap) begin
            s_d.capf = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else if (dual_mode) begin
        // dual slope: turn at top, and at bottom after a downward run
        if (at_top) begin
          s_d.dir = DOWN;
          s_d.cnt = s_q.cnt - 16'h0001;
          if (top_is_a) begin
            s_d.cmpaf = 1'b1;
          end
          if (top_is_cap) begin
            s_d.capf = 1'b1;
          end
        end else if (s_q.dir == DOWN && !at_bottom) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end else if (at_bottom) begin
          s_d.dir = UP;
          s_d.cnt = s_q.cnt + 16'h0001;
          if (s_q.dir == DOWN) begin
            s_d.ovf = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else begin
        // free count for codes without a waveform
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == 16'hFFFF) begin
          s_d.ovf = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.cnt <= tpw_pkg::CNT_RESET;
      s_q.dir <= UP;
      s_q.cap <= tpw_pkg::CMP_RESET;
      s_q.ovf <= 1'b0;
      s_q.capf <= 1'b0;
      s_q.cmpaf <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign counter_value = s_q.cnt;
  assign compare_a_register = ocr_a;
  assign capture_top_register = s_q.cap;
  assign overflow_flag = s_q.ovf;
  assign capture_flag = s_q.capf;
  assign compare_a_flag = s_q.cmpaf;
  assign channel_a_output_pin = ch_pin[0];
  assign channel_b_output_pin = ch_pin[1];
  assign channel_c_output_pin = ch_pin[2];
endmodule : tpw_timer

/* File: verif/tpw_timer_sva.sv */
/*
  checker for the pwm waveform timer: counter turning points, overflow flag and pin timing.
  assumes prescale /1 for the timing relations; the pin follows a match by one cycle.
*/
`timescale 1ns/1ps
module tpw_timer_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] waveform_mode_select,
  input wire logic [2:0] prescale_select,
  input wire logic [1:0] channel_a_output_mode,
  input wire logic [2:0] output_pin_direction_bit,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_a_register,
  input wire logic overflow_flag,
  input wire logic channel_a_output_pin,
  input wire logic channel_b_output_pin
);
  logic fp8;
  logic pc8;
  logic a_ni;
  logic a_inv;
  logic a_mid;
  assign fp8 = (waveform_mode_select == tpw_pkg::WM_FP8) && (prescale_select == tpw_pkg::PS_DIV1);
  assign pc8 = (waveform_mode_select == tpw_pkg::WM_PC8) && (prescale_select == tpw_pkg::PS_DIV1);
  // compare values away from both ends, where the edges are unambiguous
  assign a_mid = output_pin_direction_bit[0] && (compare_a_register != 16'h0000) &&
      (compare_a_register != 16'h00FF);
  assign a_ni = fp8 && a_mid && (channel_a_output_mode == tpw_pkg::OM_NONINV);
  assign a_inv = pc8 && a_mid && (channel_a_output_mode == tpw_pkg::OM_INV);
  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);
  AST_PC_TOP_HOLD: assert property (
    pc8 && counter_value == 16'h00FF |=> counter_value == 16'h00FE)
    else $error("top not followed by top minus one");
  AST_FAST_WRAP: assert property (
    fp8 && counter_value == 16'h00FF |=> counter_value == 16'h0000)
    else $error("fast counter did not wrap");
  AST_PC_OVF_AT_ZERO: assert property (
    pc8 && counter_value == 16'h0000 && $past(counter_value) == 16'h0001 |-> ##[0:1] overflow_flag)
    else $error("overflow not set at bottom");
  AST_PIN_MASKED: assert property (
    !output_pin_direction_bit[1] [*3] |-> !channel_b_output_pin)
    else $error("pin driven while direction is input");
  AST_FAST_SET_AT_MATCH: assert property (
    a_ni && counter_value == compare_a_register |-> ##1 channel_a_output_pin)
    else $error("fast output not set at match");
  AST_FAST_CLEAR_AT_WRAP: assert property (
    a_ni && counter_value == 16'h00FF |-> ##1 !channel_a_output_pin)
    else $error("fast output not cleared at wrap");
  AST_PC_UP_MATCH: assert property (
    a_inv && counter_value == compare_a_register && $past(counter_value) < counter_value
    |-> ##1 channel_a_output_pin)
    else $error("inverted output not set on rising match");
  AST_PC_DOWN_MATCH: assert property (
    a_inv && counter_value == compare_a_register && $past(counter_value) > counter_value
    |-> ##1 !channel_a_output_pin)
    else $error("inverted output not cleared on falling match");
  AST_FAST_LOAD_AT_WRAP: assert property (
    fp8 && $changed(compare_a_register) |-> counter_value == 16'h0000)
    else $error("compare loaded away from wrap");
  COV_FAST_WRAP: cover property (fp8 && counter_value == 16'h00FF);
  COV_PC_OVF: cover property (pc8 && overflow_flag);
  COV_PINS_HIGH: cover property (channel_a_output_pin && channel_b_output_pin);
endmodule : tpw_timer_sva

bind tpw_timer tpw_timer_sva u_sva (
  .clk(clk),
  .rst(rst),
  .waveform_mode_select(waveform_mode_select),
  .prescale_select(prescale_select),
  .channel_a_output_mode(channel_a_output_mode),
  .output_pin_direction_bit(output_pin_direction_bit),
  .counter_value(counter_value),
  .compare_a_register(compare_a_register),
  .overflow_flag(overflow_flag),
  .channel_a_output_pin(channel_a_output_pin),
  .channel_b_output_pin(channel_b_output_pin)
);

/* File: verif/tpw_load.sv */
/*
  load on a pwm pin: measures rise-to-rise period and high time of the last period.
  assumes the pin is sampled on the timer clock; rst clears the measurement.
*/
`timescale 1ns/1ps
module tpw_load (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic [15:0] period,
  output logic [15:0] high_len
);
  logic pin_q;
  logic [15:0] cnt;
  logic [15:0] hi;
  always @(posedge clk) begin
    pin_q <= pin;
    if (rst) begin
      period <= 16'h0000;
      high_len <= 16'h0000;
      cnt <= 16'h0000;
      hi <= 16'h0000;
    end else if (pin === 1'b1 && pin_q === 1'b0) begin
      period <= cnt;
      high_len <= hi;
      cnt <= 16'h0001;
      hi <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
      hi <= hi + {15'h0000, pin === 1'b1};
    end
  end
endmodule : tpw_load

/* File: verif/tb_top.sv */
/*
  testbench for the pwm waveform timer: table of mode runs measured on pins a and b.
  assumes the timer and the pin loads sit in this module; inputs change at falling edges.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst;
  logic [3:0] waveform_mode_select;
  logic [2:0] prescale_select;
  logic [1:0] channel_a_output_mode;
  logic [1:0] channel_b_output_mode;
  logic [1:0] channel_c_output_mode;
  logic [2:0] output_pin_direction_bit;
  logic [2:0] cmp_write;
  logic [15:0] cmp_wdata;
  logic cap_write;
  logic [15:0] cap_wdata;
  logic overflow_clear;
  logic capture_clear;
  logic compare_a_clear;
  logic [15:0] counter_value;
  logic [15:0] compare_a_register;
  logic [15:0] capture_top_register;
  logic overflow_flag;
  logic capture_flag;
  logic compare_a_flag;
  logic channel_a_output_pin;
  logic channel_b_output_pin;
  logic channel_c_output_pin;
  logic [15:0] per_a;
  logic [15:0] per_b;
  logic [15:0] hi_b;
  logic [3:0] mm [3];
  logic [15:0] mk [3];
  int mismatches;
  int num_checks;

  tpw_timer u_dut (
    .clk(clk),
    .rst(rst),
    .waveform_mode_select(waveform_mode_select),
    .prescale_select(prescale_select),
    .channel_a_output_mode(channel_a_output_mode),
    .channel_b_output_mode(channel_b_output_mode),
    .channel_c_output_mode(channel_c_output_mode),
    .output_pin_direction_bit(output_pin_direction_bit),
    .cmp_write(cmp_write),
    .cmp_wdata(cmp_wdata),
    .cap_write(cap_write),
    .cap_wdata(cap_wdata),
    .overflow_clear(overflow_clear),
    .capture_clear(capture_clear),
    .compare_a_clear(compare_a_clear),
    .counter_value(counter_value),
    .compare_a_register(compare_a_register),
    .capture_top_register(capture_top_register),
    .overflow_flag(overflow_flag),
    .capture_flag(capture_flag),
    .compare_a_flag(compare_a_flag),
    .channel_a_output_pin(channel_a_output_pin),
    .channel_b_output_pin(channel_b_output_pin),
    .channel_c_output_pin(channel_c_output_pin)
  );
  tpw_load u_load_a (.clk(clk), .rst(rst), .pin(channel_a_output_pin), .period(per_a),
      .high_len());
  tpw_load u_load_b (.clk(clk), .rst(rst), .pin(channel_b_output_pin), .period(per_b),
      .high_len(hi_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic cfg(input logic [3:0] m, input logic [2:0] ps, input logic [1:0] oa,
      input logic [1:0] ob, input logic db);
    @(negedge clk);
    rst = 1'b1;
    waveform_mode_select = m;
    prescale_select = ps;
    channel_a_output_mode = oa;
    channel_b_output_mode = ob;
    channel_c_output_mode = ob;
    output_pin_direction_bit = {1'b1, db, 1'b1};
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask : cfg

  // strobes stay up between calls; the caller drops them after the last write
  task automatic wr(input logic [2:0] w, input logic c, input logic [15:0] d);
    cmp_write = w;
    cap_write = c;
    cmp_wdata = d;
    cap_wdata = d;
    @(negedge clk);
  endtask : wr

  task automatic run(input logic [3:0] m, input logic [2:0] ps, input logic [1:0] oa,
      input logic [1:0] ob, input logic db, input logic [15:0] ca, input logic [15:0] cb,
      input logic [15:0] cap, input int pb, input int hb, input int pa);
    int n;
    n = 0;
    // top and compares are loaded in free count, where writes land at once,
    // so every pwm mode starts from a legal top
    cfg(4'h0, ps, oa, ob, db);
    wr(3'h0, 1'b1, cap);
    wr(3'h1, 1'b0, ca);
    wr(3'h2, 1'b0, cb);
    cmp_write = 3'h0;
    cap_write = 1'b0;
    waveform_mode_select = m;
    repeat (3 * (pb + pa + 600)) @(negedge clk);
    if (pb == 0) begin
      repeat (600) begin
        @(negedge clk);
        if (channel_b_output_pin === 1'b1) n++;
      end
      chk("b_level", n, hb);
    end else if (hb == 0) begin
      chk("b_spike", (hi_b === 16'h0001) || (hi_b === pb - 1), 32'h1);
    end else begin
      chk("b_high", hi_b, hb);
    end
    if (pb != 0) chk("b_period", per_b, pb);
    if (pa != 0) chk("a_period", per_a, pa);
    chk("overflow", overflow_flag, 32'h1);
    if (m == 4'hA) chk("capture_flag", capture_flag, 32'h1);
    if (m == 4'hB) chk("compare_a_flag", compare_a_flag, 32'h1);
    $display("test mode %0h done", m);
  endtask : run

  initial begin
    rst = 1'b1;
    {waveform_mode_select, prescale_select, output_pin_direction_bit} = 10'h000;
    {channel_a_output_mode, channel_b_output_mode, channel_c_output_mode} = 6'h00;
    {cmp_write, cmp_wdata, cap_write, cap_wdata} = 36'h0;
    {overflow_clear, capture_clear, compare_a_clear} = 3'h0;
    mismatches = 0;
    num_checks = 0;
    mm = '{4'h5, 4'h2, 4'h7};
    mk = '{16'h00FF, 16'h01FF, 16'h03FF};
    repeat (2) @(negedge clk);
    run(4'h5, 3'h1, 2'h2, 2'h2, 1'b1, 16'h0040, 16'h0040, 16'h0, 256, 191, 0);
    run(4'h5, 3'h1, 2'h0, 2'h3, 1'b1, 16'h0, 16'h0040, 16'h0, 256, 65, 0);
    run(4'h5, 3'h2, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0040, 16'h0, 2048, 1528, 0);
    run(4'h6, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0100, 16'h0, 512, 255, 0);
    run(4'h7, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0200, 16'h0, 1024, 511, 0);
    run(4'h5, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0000, 16'h0, 256, 0, 0);
    run(4'h5, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h00FF, 16'h0, 0, 600, 0);
    run(4'h5, 3'h1, 2'h0, 2'h3, 1'b1, 16'h0, 16'h00FF, 16'h0, 0, 0, 0);
    run(4'h5, 3'h1, 2'h0, 2'h2, 1'b0, 16'h0, 16'h0040, 16'h0, 0, 0, 0);
    run(4'h1, 3'h1, 2'h3, 2'h2, 1'b1, 16'h0040, 16'h0040, 16'h0, 510, 128, 0);
    run(4'h2, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0100, 16'h0, 1022, 512, 0);
    run(4'h3, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0200, 16'h0, 2046, 1024, 0);
    run(4'hA, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0010, 16'h0030, 96, 32, 0);
    run(4'hB, 3'h1, 2'h1, 2'h2, 1'b1, 16'h0004, 16'h0002, 16'h0, 8, 4, 16);
    run(4'h1, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0000, 16'h0, 0, 0, 0);
    run(4'h1, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h00FF, 16'h0, 0, 600, 0);
    run(4'h8, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0, 16'h0010, 16'h0020, 64, 32, 0);
    run(4'h9, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0020, 16'h0008, 16'h0, 64, 16, 0);
    run(4'h9, 3'h1, 2'h0, 2'h2, 1'b1, 16'h0004, 16'h0002, 16'h0, 8, 4, 0);
    run(4'hF, 3'h1, 2'h1, 2'h2, 1'b1, 16'h0003, 16'h0001, 16'h0, 4, 2, 8);
    for (int i = 0; i < 3; i++) begin
      cfg(mm[i], 3'h1, 2'h2, 2'h2, 1'b1);
      wr(3'h1, 1'b0, 16'hABCD);
      cmp_write = 3'h0;
      chk("a_buffered", compare_a_register, 32'h0);
      repeat (2200) @(negedge clk);
      chk("a_masked", compare_a_register, {16'h0, 16'hABCD & mk[i]});
      $display("test mask %0d done", i);
    end
    chk("overflow_before_clear", overflow_flag, 32'h1);
    prescale_select = 3'h0;
    {overflow_clear, capture_clear, compare_a_clear} = 3'h7;
    @(negedge clk);
    {overflow_clear, capture_clear, compare_a_clear} = 3'h0;
    @(negedge clk);
    chk("overflow_cleared", overflow_flag, 32'h0);
    chk("capture_cleared", capture_flag, 32'h0);
    chk("compare_a_cleared", compare_a_flag, 32'h0);
    $display("test clear done");
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : tb_top
